// *** src/msp_host.sv ***
`timescale 1ns/1ps
module msp_host import msp_pkg::*; #(
    parameter int PDW_CYC     = PDW_CYCLES,
    parameter int COMPUTE_CYC = COMPUTE_CYCLES,
    parameter int SETTLE_CYC  = SETTLE_CYCLES
) (
    // system
    input  wire logic       CLK,
    input  wire logic       RST,
    // link
    msp_link_if.host        LINK,
    // transaction request
    input  wire logic       START,
    input  wire logic       WRITE,
    input  wire logic [6:0] ADDR,
    input  wire logic [7:0] WDATA,
    output logic            BUSY,
    output logic            DONE,
    output logic [7:0]      RDATA,
    // power control
    input  wire logic       POWER_DOWN,
    input  wire logic       PORT_RESET,
    input  wire logic       MOVED,
    output logic            DATA_READY
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_GAP  = 3'b001,
        H_ADDR = 3'b010,
        H_HOLD = 3'b011,
        H_DATA = 3'b100,
        H_PD   = 3'b101,
        H_WAKE = 3'b110
    } msp_hstate_type;

    msp_hstate_type state;
    logic [1:0]     sdio_s;
    logic [2:0]     ph;
    logic [2:0]     bit_cnt;
    logic [7:0]     shreg;
    logic [7:0]     rd_sr;
    logic           req_write;
    logic [7:0]     req_data;
    logic           last_write;
    logic [11:0]    since;
    logic [31:0]    tmr;
    logic           rst_req;
    logic           long_pd;
    logic           moved_seen;
    logic           bit_end;

    // ------------------------------------------------------------
    // gap selection
    // ------------------------------------------------------------
    function automatic logic gap_met(input logic prev_wr, input logic next_wr,
                                     input logic [11:0] elapsed);
        int need;
        need = prev_wr ? (next_wr ? SWW_CYC : SWR_CYC)
                       : (next_wr ? SRW_CYC : SRR_CYC);
        return elapsed >= 12'(need);
    endfunction : gap_met

    assign bit_end = (ph == 3'(2 * SCLK_HALF - 1));

    // ------------------------------------------------------------
    // data line synchroniser and gap counter
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST)
            sdio_s <= 2'h3;
        else
            sdio_s <= {sdio_s[0], LINK.sdio};
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST)
            since <= 12'(SWW_CYC);
        else if (state == H_DATA && bit_end && bit_cnt == 3'h7)
            since <= 12'h0;
        else if (since < 12'(SWW_CYC))
            since <= since + 12'h1;
    end

    // ------------------------------------------------------------
    // power request capture
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST)
            rst_req <= 1'b0;
        else if (PORT_RESET)
            rst_req <= 1'b1;
        else if (state == H_PD)
            rst_req <= 1'b0;
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST)
            moved_seen <= 1'b0;
        else if (state == H_PD)
            moved_seen <= moved_seen | MOVED;
        else if (state == H_IDLE)
            moved_seen <= 1'b0;
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state               <= H_WAKE;
            BUSY                <= 1'b1;
            DONE                <= 1'b0;
            RDATA               <= 8'h00;
            DATA_READY          <= 1'b0;
            LINK.sclk           <= 1'b1;
            LINK.sdio_h_o       <= 1'b1;
            LINK.sdio_h_oe      <= 1'b0;
            LINK.power_down_pin <= 1'b0;
            ph                  <= 3'h0;
            bit_cnt             <= 3'h0;
            shreg               <= 8'h00;
            rd_sr               <= 8'h00;
            req_write           <= 1'b0;
            req_data            <= 8'h00;
            last_write          <= 1'b0;
            tmr                 <= 32'h0;
            long_pd             <= 1'b0;
        end else begin
            DONE <= 1'b0;
            case (state)
                H_IDLE: begin
                    if (POWER_DOWN || rst_req) begin
                        state               <= H_PD;
                        BUSY                <= 1'b1;
                        DATA_READY          <= 1'b0;
                        LINK.power_down_pin <= 1'b1;
                        long_pd             <= POWER_DOWN;
                        tmr                 <= 32'h0;
                    end else if (START) begin
                        state     <= H_GAP;
                        BUSY      <= 1'b1;
                        req_write <= WRITE;
                        req_data  <= WDATA;
                        shreg     <= {WRITE, ADDR};
                    end
                end
                H_GAP: begin
                    if (gap_met(last_write, req_write, since)) begin
                        state          <= H_ADDR;
                        ph             <= 3'h0;
                        bit_cnt        <= 3'h0;
                        LINK.sdio_h_oe <= 1'b1;
                    end
                end
                H_ADDR, H_DATA: begin
                    ph <= bit_end ? 3'h0 : ph + 3'h1;
                    if (ph == 3'h0) begin
                        LINK.sclk <= 1'b0;
                        if (LINK.sdio_h_oe) begin
                            LINK.sdio_h_o <= shreg[7];
                            shreg         <= {shreg[6:0], 1'b0};
                        end
                    end
                    if (ph == 3'(SCLK_HALF))
                        LINK.sclk <= 1'b1;
                    if (ph == 3'(SAMPLE_PH))
                        rd_sr <= {rd_sr[6:0], sdio_s[1]};
                    if (bit_end) begin
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7 && state == H_ADDR) begin
                            if (req_write) begin
                                state <= H_DATA;
                                shreg <= req_data;
                            end else begin
                                state          <= H_HOLD;
                                LINK.sdio_h_oe <= 1'b0;
                                tmr            <= 32'h0;
                            end
                        end else if (bit_cnt == 3'h7) begin
                            state          <= H_IDLE;
                            BUSY           <= 1'b0;
                            DONE           <= 1'b1;
                            LINK.sdio_h_oe <= 1'b0;
                            last_write     <= req_write;
                            if (!req_write)
                                RDATA <= rd_sr;
                        end
                    end
                end
                H_HOLD: begin
                    tmr <= tmr + 32'h1;
                    if (tmr >= 32'(HOLD_CYC - 1)) begin
                        state   <= H_DATA;
                        ph      <= 3'h0;
                        bit_cnt <= 3'h0;
                    end
                end
                H_PD: begin
                    if (tmr != 32'hffff_ffff)
                        tmr <= tmr + 32'h1;
                    if ((long_pd && tmr >= 32'(PDW_CYC - 1) && !POWER_DOWN)
                        || (!long_pd && tmr >= 32'(PDR_CYC - 1))) begin
                        state               <= H_WAKE;
                        LINK.power_down_pin <= 1'b0;
                        tmr                 <= 32'h0;
                    end
                end
                H_WAKE: begin
                    tmr <= tmr + 32'h1;
                    if (tmr >= 32'(COMPUTE_CYC - 1) + (moved_seen ? 32'(SETTLE_CYC) : 32'h0)) begin
                        state      <= H_IDLE;
                        BUSY       <= 1'b0;
                        DATA_READY <= 1'b1;
                    end
                end
                default: state <= H_IDLE;
            endcase
        end
    end
endmodule : msp_host

// *** src/msp_pkg.sv ***
package msp_pkg;
    // ------------------------------------------------------------
    // clocks and link
    // ------------------------------------------------------------
    localparam int  CLK_PERIOD_NS   = 50;
    localparam int  CLK_HZ          = 20_000_000;
    localparam real SENSOR_CLK_MHZ  = 18.0;
    localparam int  SCLK_DIV        = 4;
    localparam int  SCLK_HALF       = 4;
    localparam int  SAMPLE_PH       = SCLK_HALF + 2;
    localparam int  BYTE_BITS       = 8;
    localparam int  WRITE_BIT       = 7;
    localparam int  NUM_REGS        = 16;
    localparam int  FRAME_REG       = 0;
    localparam int  CONFIG_REG      = 1;
    // ------------------------------------------------------------
    // timing, each figure in its own unit
    // ------------------------------------------------------------
    localparam int  T_HOLD_US       = 100;
    localparam int  T_SWW_US        = 100;
    localparam int  T_SWR_US        = 100;
    localparam int  T_SRW_NS        = 120;
    localparam int  T_SRR_NS        = 120;
    localparam real T_COMPUTE_MS    = 3.2;
    localparam int  SETTLE_FRAMES   = 75;
    localparam int  T_PDW_US        = 700;
    localparam int  T_PDR_US        = 100;
    localparam int  FRAME_RATE_FPS  = 1500;
    localparam real T_TMO_MIN_S     = 0.7;
    localparam real T_TMO_MAX_S     = 1.0;
    // ------------------------------------------------------------
    // cycle counts
    // ------------------------------------------------------------
    function automatic int msp_ns_ceil(input longint ns);
        longint c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : int'(c);
    endfunction : msp_ns_ceil

    localparam int HOLD_CYC    = msp_ns_ceil(longint'(T_HOLD_US) * 1000);
    localparam int SWW_CYC     = msp_ns_ceil(longint'(T_SWW_US) * 1000);
    localparam int SWR_CYC     = msp_ns_ceil(longint'(T_SWR_US) * 1000);
    localparam int SRW_CYC     = msp_ns_ceil(longint'(T_SRW_NS));
    localparam int SRR_CYC     = msp_ns_ceil(longint'(T_SRR_NS));
    localparam int PDR_CYC     = msp_ns_ceil(longint'(T_PDR_US) * 1000);
    localparam int PDW_CYCLES  = msp_ns_ceil(longint'(T_PDW_US) * 1000);
    localparam int COMPUTE_CYCLES = msp_ns_ceil(longint'(T_COMPUTE_MS * 1.0e6));
    localparam int FRAME_CYCLES   = CLK_HZ / FRAME_RATE_FPS;
    localparam int SETTLE_CYCLES  = SETTLE_FRAMES * FRAME_CYCLES;
    localparam int TIMEOUT_CYCLES = msp_ns_ceil(longint'(T_TMO_MIN_S * 1.0e9));
endpackage : msp_pkg

// *** src/msp_link_if.sv ***
`timescale 1ns/1ps
interface msp_link_if;
    logic sclk;
    logic sdio_h_o;
    logic sdio_h_oe;
    logic sdio_d_o;
    logic sdio_d_oe;
    logic power_down_pin;
    logic sdio;

    // resolved data line, pulled high when nobody drives
    assign sdio = sdio_h_oe ? sdio_h_o : (sdio_d_oe ? sdio_d_o : 1'b1);

    modport host (output sclk, sdio_h_o, sdio_h_oe, power_down_pin, input sdio);
    modport sensor (input sclk, power_down_pin, sdio, output sdio_d_o, sdio_d_oe);
endinterface : msp_link_if

// *** src/msp_sensor.sv ***
`timescale 1ns/1ps
module msp_sensor import msp_pkg::*; #(
    parameter int PDW_CYC     = PDW_CYCLES,
    parameter int FRAME_CYC   = FRAME_CYCLES,
    parameter int TIMEOUT_CYC = TIMEOUT_CYCLES
) (
    // system
    input  wire logic       CLK,
    input  wire logic       RST,
    // link
    msp_link_if.sensor      LINK,
    // user side
    input  wire logic [7:0] FRAME_DATA,
    output logic            POWERED_DOWN,
    output logic            REGS_VALID,
    output logic [7:0]      CONFIG
);
    typedef enum logic [1:0] {
        SP_ADDR  = 2'b00,
        SP_WDATA = 2'b01,
        SP_RDATA = 2'b10
    } msp_sp_type;

    logic [1:0]  sclk_s;
    logic [1:0]  sdio_s;
    logic [1:0]  pd_s;
    logic        sclk_d;
    logic        rise;
    logic        fall;
    logic [31:0] pd_cnt;
    logic [31:0] frame_cnt;
    logic [31:0] tmo_cnt;
    logic        frame_tick;
    logic        port_clr;
    msp_sp_type  sp;
    logic [2:0]  bit_cnt;
    logic [7:0]  shreg;
    logic [7:0]  out_sr;
    logic [3:0]  addr;
    logic [7:0]  regs [NUM_REGS];

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sclk_s <= 2'h3;
            sdio_s <= 2'h3;
            pd_s   <= 2'h0;
            sclk_d <= 1'b1;
        end else begin
            sclk_s <= {sclk_s[0], LINK.sclk};
            sdio_s <= {sdio_s[0], LINK.sdio};
            pd_s   <= {pd_s[0], LINK.power_down_pin};
            sclk_d <= sclk_s[1];
        end
    end

    assign rise = sclk_s[1] & ~sclk_d;
    assign fall = ~sclk_s[1] & sclk_d;
    assign frame_tick = (frame_cnt == 32'(FRAME_CYC - 1));
    assign port_clr = (pd_cnt >= 32'(PDR_CYC)) || (tmo_cnt >= 32'(TIMEOUT_CYC - 1));

    // ------------------------------------------------------------
    // power-down pin
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pd_cnt       <= 32'h0;
            POWERED_DOWN <= 1'b0;
        end else if (pd_s[1]) begin
            if (pd_cnt != 32'hffff_ffff)
                pd_cnt <= pd_cnt + 32'h1;
            if (pd_cnt >= 32'(PDW_CYC - 1))
                POWERED_DOWN <= 1'b1;
        end else begin
            pd_cnt       <= 32'h0;
            POWERED_DOWN <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // frame timing
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST)
            frame_cnt <= 32'h0;
        else if (POWERED_DOWN || frame_tick)
            frame_cnt <= 32'h0;
        else
            frame_cnt <= frame_cnt + 32'h1;
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST)
            REGS_VALID <= 1'b0;
        else if (POWERED_DOWN)
            REGS_VALID <= 1'b0;
        else if (frame_tick)
            REGS_VALID <= 1'b1;
    end

    // ------------------------------------------------------------
    // transaction timer
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST)
            tmo_cnt <= 32'h0;
        else if (port_clr || (sp == SP_ADDR && bit_cnt == 3'h0))
            tmo_cnt <= 32'h0;
        else
            tmo_cnt <= tmo_cnt + 32'h1;
    end

    // ------------------------------------------------------------
    // serial port
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sp             <= SP_ADDR;
            bit_cnt        <= 3'h0;
            shreg          <= 8'h00;
            out_sr         <= 8'h00;
            addr           <= 4'h0;
            LINK.sdio_d_o  <= 1'b1;
            LINK.sdio_d_oe <= 1'b0;
        end else if (port_clr || pd_s[1]) begin
            sp             <= SP_ADDR;
            bit_cnt        <= 3'h0;
            LINK.sdio_d_oe <= 1'b0;
        end else begin
            case (sp)
                SP_ADDR: begin
                    if (rise) begin
                        shreg   <= {shreg[6:0], sdio_s[1]};
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7) begin
                            addr   <= {shreg[2:0], sdio_s[1]};
                            out_sr <= regs[{shreg[2:0], sdio_s[1]}];
                            sp     <= shreg[WRITE_BIT - 1] ? SP_WDATA : SP_RDATA;
                        end
                    end
                end
                SP_WDATA: begin
                    if (rise) begin
                        shreg   <= {shreg[6:0], sdio_s[1]};
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7)
                            sp <= SP_ADDR;
                    end
                end
                SP_RDATA: begin
                    if (fall) begin
                        LINK.sdio_d_o  <= out_sr[7];
                        LINK.sdio_d_oe <= 1'b1;
                        out_sr         <= {out_sr[6:0], 1'b0};
                    end else if (rise) begin
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7) begin
                            sp             <= SP_ADDR;
                            LINK.sdio_d_oe <= 1'b0;
                        end
                    end
                end
                default: sp <= SP_ADDR;
            endcase
        end
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < NUM_REGS; i++)
                regs[i] <= 8'h00;
        end else begin
            if (frame_tick)
                regs[FRAME_REG] <= FRAME_DATA;
            if (sp == SP_WDATA && rise && bit_cnt == 3'h7 && !port_clr && !pd_s[1]
                && addr != 4'(FRAME_REG))
                regs[addr] <= {shreg[6:0], sdio_s[1]};
        end
    end

    assign CONFIG = regs[CONFIG_REG];
endmodule : msp_sensor

// *** tb/msp_link_monitor.sv ***
`timescale 1ns/1ps
module msp_link_monitor import msp_pkg::*; #(
    parameter int PDW_CYC     = PDW_CYCLES,
    parameter int COMPUTE_CYC = COMPUTE_CYCLES
) (
    // system
    input wire logic CLK,
    input wire logic RST,
    // link
    input wire logic sclk,
    input wire logic sdio_h_oe,
    input wire logic sdio_d_oe,
    input wire logic power_down_pin
);
    // ----------------------------------------
    // helper counters
    // ----------------------------------------
    logic        oe_q;
    logic        armed;
    logic [15:0] since_rel;
    logic [15:0] pd_cnt;
    logic [15:0] wake_cnt;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            oe_q      <= 1'b0;
            armed     <= 1'b0;
            since_rel <= 16'h0;
        end else begin
            oe_q <= sdio_h_oe;
            if (oe_q && !sdio_h_oe) begin
                armed     <= 1'b1;
                since_rel <= 16'h0;
            end else begin
                if (!sclk) begin
                    armed <= 1'b0;
                end
                if (since_rel != 16'hffff) begin
                    since_rel <= since_rel + 16'h1;
                end
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pd_cnt   <= 16'h0;
            wake_cnt <= 16'h0;
        end else begin
            pd_cnt   <= !power_down_pin ? 16'h0 :
                        (pd_cnt == 16'hffff) ? pd_cnt : pd_cnt + 16'h1;
            wake_cnt <= (power_down_pin) ? 16'h0 :
                        (wake_cnt == 16'hffff) ? wake_cnt : wake_cnt + 16'h1;
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_low_phase;
        !sclk [*4];
    endsequence

    sequence s_high_phase;
        sclk [*4];
    endsequence

    sclk_low_a: assert property ($fell(sclk) |-> s_low_phase)
        else $error("serial clock low phase too short");
    sclk_high_a: assert property ($rose(sclk) |-> s_high_phase)
        else $error("serial clock high phase too short");
    read_hold_a: assert property ($fell(sclk) && armed && !sdio_h_oe |-> since_rel >= HOLD_CYC)
        else $error("read data clocked before hold time");
    write_gap_a: assert property ($fell(sclk) && armed && sdio_h_oe |-> since_rel >= SWW_CYC)
        else $error("transaction started too soon after write");
    no_contention_a: assert property (!(sdio_h_oe && sdio_d_oe))
        else $error("both ends drive data line");
    sensor_drive_a: assert property ($rose(sdio_d_oe) |-> !sclk && !sdio_h_oe)
        else $error("sensor drives outside read data phase");
    pd_width_a: assert property ($fell(power_down_pin) |-> pd_cnt >= PDW_CYC || pd_cnt >= PDR_CYC)
        else $error("power-down pulse too short");
    pd_idle_a: assert property (power_down_pin [*4] |-> sclk && !sdio_d_oe)
        else $error("port active while power-down pin high");
    wake_quiet_a: assert property ($fell(sclk) |-> wake_cnt >= COMPUTE_CYC)
        else $error("transaction before wake delay ended");
endmodule : msp_link_monitor

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top import msp_pkg::*;;
    // ----------------------------------------
    // bench setup
    // ----------------------------------------
    localparam int PDW = 40;
    localparam int COMP = 100;
    localparam int SETTLE = 50;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        start, write, busy, done, power_down, port_reset, moved, data_ready;
    logic [6:0]  addr;
    logic [7:0]  wdata, rdata, frame, config_out, d;
    logic        powered_down, regs_valid;
    logic [31:0] lfsr = 32'd66631;
    logic [31:0] cnt;
    logic [7:0]  regs_exp [16];
    int          errors = 0;
    int          n_tests = 0;

    msp_link_if link();
    msp_host #(.PDW_CYC(PDW), .COMPUTE_CYC(COMP), .SETTLE_CYC(SETTLE)) u_msp_host (
        .CLK(clk), .RST(rst), .LINK(link), .START(start), .WRITE(write), .ADDR(addr),
        .WDATA(wdata), .BUSY(busy), .DONE(done), .RDATA(rdata), .POWER_DOWN(power_down),
        .PORT_RESET(port_reset), .MOVED(moved), .DATA_READY(data_ready));
    msp_sensor #(.PDW_CYC(PDW), .FRAME_CYC(20), .TIMEOUT_CYC(5000)) u_msp_sensor (
        .CLK(clk), .RST(rst), .LINK(link), .FRAME_DATA(frame),
        .POWERED_DOWN(powered_down), .REGS_VALID(regs_valid), .CONFIG(config_out));
    msp_link_monitor #(.PDW_CYC(PDW), .COMPUTE_CYC(COMP)) u_msp_link_monitor (
        .CLK(clk), .RST(rst), .sclk(link.sclk), .sdio_h_oe(link.sdio_h_oe),
        .sdio_d_oe(link.sdio_d_oe), .power_down_pin(link.power_down_pin));

    always #25 clk = ~clk;

    function automatic logic [7:0] rnd();
        for (int i = 0; i < 8; i++) begin
            lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        end
        return lfsr[7:0];
    endfunction : rnd

    function automatic logic [7:0] exp_rd(input logic [6:0] a);
        return (a[3:0] == 4'h0) ? frame : regs_exp[a[3:0]];
    endfunction : exp_rd

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic cmp8(input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : cmp8

    task automatic cmp32(input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : cmp32

    task automatic wait_sig(ref logic s, input int lim);
        for (int i = 0; i < lim && s !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        cmp8(8'h01, {7'h0, s});
    endtask : wait_sig

    task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] v);
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #2;
        start = 1'b1;
        write = wr;
        addr  = a;
        wdata = v;
        @(posedge clk);
        #2;
        start = 1'b0;
        wait_sig(done, 6000);
        if (wr && a[3:0] != 4'h0) begin
            regs_exp[a[3:0]] = v;
        end
    endtask : xfer

    task automatic conclude();
        $display("tests=%0d errors=%0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        {start, write, power_down, port_reset, moved} = 5'h0;
        addr  = 7'h0;
        wdata = 8'h0;
        frame = rnd();
        repeat (2) @(posedge clk);
        #2 rst = 1'b0;
        wait_sig(data_ready, COMP + 50);
        cmp8(8'h01, {7'h0, regs_valid});
        for (int k = 0; k < 4; k++) begin
            d = rnd();
            xfer(1'b1, 7'h01, d);
            cmp8(d, config_out);
            d = rnd();
            addr = (k == 3) ? 7'h0 : {d[6:4], (d[3:0] == 4'h0) ? 4'h2 : d[3:0]};
            xfer(1'b1, addr, rnd());
            xfer(1'b0, addr, 8'h0);
            cmp8(exp_rd(addr), rdata);
            xfer(1'b0, 7'h01, 8'h0);
            cmp8(regs_exp[1], rdata);
        end
        @(posedge clk);
        #2;
        power_down = 1'b1;
        moved = 1'b1;
        repeat (60) @(posedge clk);
        #1;
        cmp8(8'h01, {7'h0, link.power_down_pin});
        cmp8(8'h01, {7'h0, powered_down});
        cmp8(8'h00, {7'h0, regs_valid});
        #1 power_down = 1'b0;
        frame = rnd();
        cnt = 0;
        while (data_ready !== 1'b1 && cnt < 1000) begin
            @(posedge clk);
            #1 cnt++;
        end
        cmp8(8'h01, {7'h0, cnt >= COMP + SETTLE && cnt <= COMP + SETTLE + 10});
        moved = 1'b0;
        xfer(1'b0, 7'h0, 8'h0);
        cmp8(frame, rdata);
        cmp8(8'h01, {7'h0, regs_valid && !powered_down});
        @(posedge clk);
        #2 port_reset = 1'b1;
        @(posedge clk);
        #2 port_reset = 1'b0;
        wait_sig(link.power_down_pin, 10);
        cnt = 0;
        while (link.power_down_pin === 1'b1 && cnt < 3000) begin
            cnt++;
            @(posedge clk);
            #1;
        end
        cmp32(PDR_CYC, cnt);
        cnt = 0;
        while (data_ready !== 1'b1 && cnt < 1000) begin
            @(posedge clk);
            #1 cnt++;
        end
        cmp8(8'h01, {7'h0, cnt >= COMP && cnt <= COMP + 10});
        d = rnd();
        xfer(1'b1, 7'h01, d);
        xfer(1'b0, 7'h01, 8'h0);
        cmp8(d, rdata);
        conclude();
    end

    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        conclude();
    end
endmodule : tb_top
